/* File: design/rncr_cfg.svh */
// Overview of operation
// (RULE1) Frequency word: high byte 7Ah, low byte 7Bh
// (RULE2) Oscillator frequency is word times rate over 65536
// (RULE3) Bit 2 of 7Eh: 6-dB gain, modes 4/6/7
// (RULE4) Bit 1 of 7Eh: 6-dB gain, mode 0, resets one
// (RULE5) Bit 0 of 7Eh: modes 1/3, register resets 3h
// (RULE6) Converter 07h: upper overrange limit, resets FFh
// (RULE7) Converter 08h: lower overrange limit, resets zero
// (RULE8) Bit 3 of D5h enables calibration
// (RULE9) Host sets then clears calibration at start-up
// (RULE10) Reserved bits written zero, read back zero
// (RULE11) Speed select one reports fast overrange flag
// (RULE12) Flag sets above upper, clears below lower
// (RULE13) Phase accumulator adds word each sample, wraps
`ifndef RNCR_CFG_SVH
`define RNCR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RNCR_OFS_UPPER 8'h07
`define RNCR_OFS_LOWER 8'h08
`define RNCR_OFS_WORD_HI 8'h7A
`define RNCR_OFS_WORD_LO 8'h7B
`define RNCR_OFS_COMP 8'h7E
`define RNCR_OFS_CAL 8'hD5

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define RNCR_BIT_GAIN_467 2
`define RNCR_BIT_GAIN_0 1
`define RNCR_BIT_GAIN_13 0
`define RNCR_BIT_CAL_EN 3
`define RNCR_COMP_MASK 8'h07
`define RNCR_CAL_MASK 8'h08
`define RNCR_RST_UPPER 8'hFF
`define RNCR_RST_LOWER 8'h00
`define RNCR_RST_WORD 8'h00
`define RNCR_RST_COMP 8'h03
`define RNCR_RST_CAL 8'h00

// ----------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------
`define RNCR_OVR_MATCH_DELAY 4

`endif

/* File: design/rncr_pkg.sv */
package rncr_pkg;
    // One configuration byte
    typedef logic [7:0] rncr_byte_t;
    // Oscillator frequency word and phase
    typedef logic [15:0] rncr_word_t;
endpackage

/* File: design/rncr_ovr_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Thresholds out to the detector, flag back
interface rncr_ovr_if;
    rncr_pkg::rncr_byte_t upper;
    rncr_pkg::rncr_byte_t lower;
    logic speed_sel;
    logic flag;
    modport cfg (output upper, output lower, output speed_sel,
                 input flag);
    modport det (input upper, input lower, input speed_sel,
                 output flag);
endinterface
`default_nettype wire

/* File: design/rncr_ovr_det.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rncr_cfg.svh"
module rncr_ovr_det #(
    parameter int DELAY = `RNCR_OVR_MATCH_DELAY
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Sample path
    input wire logic sample_en,
    input wire logic [7:0] sample_mag,
    // Thresholds and flag
    rncr_ovr_if.det ovr
);
    // ----------------------------------------------------------------
    // Hysteresis detector
    // ----------------------------------------------------------------
    logic fast_reg; // Immediate flag
    logic fast_next;
    logic [DELAY-1:0] dly_reg; // Matches datapath latency
    logic flag_reg;
    wire logic above = sample_mag > ovr.upper;
    wire logic below = sample_mag < ovr.lower;

    // Set above upper, clear below lower, else hold
    assign fast_next = above ? 1'b1 : (below ? 1'b0 : fast_reg); // [RULE12]

    // Fast flag and delay line advance on the sample enable only; the output flag updates every cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fast_reg <= 1'b0;
            dly_reg <= '0;
            flag_reg <= 1'b0;
        end else begin
            if (sample_en) begin
                fast_reg <= fast_next;
                dly_reg <= {dly_reg[DELAY-2:0], fast_reg};
            end
            // Speed select picks the fast or matched copy
            flag_reg <= ovr.speed_sel ? fast_reg : dly_reg[DELAY-1]; // [RULE11]
        end
    end
    assign ovr.flag = flag_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_fast_set;
        @(posedge clk) disable iff (sys_rst)
        sample_en && (sample_mag > ovr.upper) |=> fast_reg;
    endproperty
    a_fast_set: assert property (p_fast_set) // [RULE12]
        else $error("fast flag not set above upper limit");

    property p_fast_clr;
        @(posedge clk) disable iff (sys_rst)
        sample_en && (sample_mag < ovr.lower) && !(sample_mag > ovr.upper)
            |=> !fast_reg;
    endproperty
    a_fast_clr: assert property (p_fast_clr) // [RULE12]
        else $error("fast flag not cleared below lower limit");

    property p_sel_fast;
        @(posedge clk) disable iff (sys_rst)
        ovr.speed_sel |=> ovr.flag == $past(fast_reg);
    endproperty
    a_sel_fast: assert property (p_sel_fast) // [RULE11]
        else $error("fast flag not reported when selected");

    c_ovr_rise: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(ovr.flag));
endmodule // rncr_ovr_det
`default_nettype wire

/* File: design/rncr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rncr_cfg.svh"
module rncr_regs #(
    parameter int OVR_DELAY = `RNCR_OVR_MATCH_DELAY
) (
    // Clock and resets
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic soft_rst,
    // Configuration port, page already selected upstream
    input wire logic channel_page,
    input wire logic converter_page,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    // Channel datapath
    input wire logic sample_en,
    input wire logic [7:0] sample_mag,
    input wire logic overrange_speed_select,
    output logic [15:0] mixer_frequency_word,
    output logic [15:0] mixer_phase,
    output logic comp_gain_modes_four_six_seven,
    output logic comp_gain_mode_zero,
    output logic comp_gain_modes_one_three,
    output logic overrange_flag,
    // Converter core
    output logic [7:0] fast_overrange_upper_limit,
    output logic [7:0] fast_overrange_lower_limit,
    output logic cal_enable
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Offset match gated by its page select
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o,
                                 input logic pg);
        hit = pg && (a == o);
    endfunction

    wire logic h_hi = hit(cfg_addr, `RNCR_OFS_WORD_HI, channel_page);
    wire logic h_lo = hit(cfg_addr, `RNCR_OFS_WORD_LO, channel_page);
    wire logic h_comp = hit(cfg_addr, `RNCR_OFS_COMP, channel_page);
    wire logic h_up = hit(cfg_addr, `RNCR_OFS_UPPER, converter_page);
    wire logic h_low = hit(cfg_addr, `RNCR_OFS_LOWER, converter_page);
    wire logic h_cal = hit(cfg_addr, `RNCR_OFS_CAL, converter_page);
    wire logic init = sys_rst || soft_rst; // Either reset reloads defaults

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    rncr_pkg::rncr_byte_t word_hi_reg; // Frequency word [15:8]
    rncr_pkg::rncr_byte_t word_lo_reg; // Frequency word [7:0]
    rncr_pkg::rncr_byte_t comp_reg; // Only bits 2:0 stored
    rncr_pkg::rncr_byte_t upper_reg;
    rncr_pkg::rncr_byte_t lower_reg;
    rncr_pkg::rncr_byte_t cal_reg; // Only bit 3 stored
    rncr_pkg::rncr_byte_t rdata_reg;
    rncr_pkg::rncr_byte_t rdata_next;
    rncr_pkg::rncr_word_t phase_reg;
    rncr_pkg::rncr_word_t phase_next;

    // Full byte registers for the word and both limits
    always_ff @(posedge clk) begin
        if (init) begin
            word_hi_reg <= `RNCR_RST_WORD; // [RULE1]
            word_lo_reg <= `RNCR_RST_WORD; // [RULE1]
            upper_reg <= `RNCR_RST_UPPER; // [RULE6]
            lower_reg <= `RNCR_RST_LOWER; // [RULE7]
        end else if (cfg_wr) begin
            if (h_hi) begin
                word_hi_reg <= cfg_wdata; // [RULE1]
            end
            if (h_lo) begin
                word_lo_reg <= cfg_wdata; // [RULE1]
            end
            if (h_up) begin
                upper_reg <= cfg_wdata; // [RULE6]
            end
            if (h_low) begin
                lower_reg <= cfg_wdata; // [RULE7]
            end
        end
    end

    // Reserved bits are masked off so they never hold a one
    always_ff @(posedge clk) begin
        if (init) begin
            comp_reg <= `RNCR_RST_COMP; // [RULE4] [RULE5]
            cal_reg <= `RNCR_RST_CAL;
        end else if (cfg_wr) begin
            if (h_comp) begin
                comp_reg <= cfg_wdata & `RNCR_COMP_MASK; // [RULE3] [RULE10]
            end
            if (h_cal) begin
                cal_reg <= cfg_wdata & `RNCR_CAL_MASK; // [RULE8] [RULE10]
            end
        end
    end

    // ----------------------------------------------------------------
    // Read back
    // ----------------------------------------------------------------
    // Unmapped or unselected offsets read zero; data lands next cycle
    assign rdata_next = !cfg_rd ? rdata_reg :
                        h_hi ? word_hi_reg :
                        h_lo ? word_lo_reg :
                        h_comp ? comp_reg :
                        h_up ? upper_reg :
                        h_low ? lower_reg :
                        h_cal ? cal_reg : 8'h00; // [RULE10]

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end
    assign cfg_rdata = rdata_reg;

    // ----------------------------------------------------------------
    // Oscillator phase
    // ----------------------------------------------------------------
    // Step equals the word, so frequency is word * fs / 65536; the
    // natural 16-bit wrap makes every word value legal
    assign phase_next = phase_reg + mixer_frequency_word; // [RULE2] [RULE13]

    always_ff @(posedge clk) begin
        if (init) begin
            phase_reg <= 16'h0000;
        end else if (sample_en) begin
            phase_reg <= phase_next; // [RULE13]
        end
    end
    assign mixer_phase = phase_reg;

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign mixer_frequency_word = {word_hi_reg, word_lo_reg}; // [RULE1]
    assign comp_gain_modes_four_six_seven = comp_reg[`RNCR_BIT_GAIN_467]; // [RULE3]
    assign comp_gain_mode_zero = comp_reg[`RNCR_BIT_GAIN_0]; // [RULE4]
    assign comp_gain_modes_one_three = comp_reg[`RNCR_BIT_GAIN_13]; // [RULE5]
    // Calibration runs only while the host holds this bit set
    assign cal_enable = cal_reg[`RNCR_BIT_CAL_EN]; // [RULE8] [RULE9]
    assign fast_overrange_upper_limit = upper_reg;
    assign fast_overrange_lower_limit = lower_reg;

    // ----------------------------------------------------------------
    // Overrange detector
    // ----------------------------------------------------------------
    rncr_ovr_if ovr_link ();
    assign ovr_link.upper = upper_reg;
    assign ovr_link.lower = lower_reg;
    assign ovr_link.speed_sel = overrange_speed_select;
    assign overrange_flag = ovr_link.flag;

    rncr_ovr_det #(
        .DELAY(OVR_DELAY)
    ) u_det (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample_en(sample_en),
        .sample_mag(sample_mag),
        .ovr(ovr_link.det)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_word_hi;
        @(posedge clk) disable iff (init)
        cfg_wr && h_hi ##1 !init |-> mixer_frequency_word[15:8] ==
            $past(cfg_wdata);
    endproperty
    a_word_hi: assert property (p_word_hi) // [RULE1]
        else $error("high word byte not written");

    property p_phase;
        @(posedge clk) disable iff (init)
        sample_en ##1 !init |-> phase_reg ==
            16'($past(phase_reg) + $past(mixer_frequency_word));
    endproperty
    a_phase: assert property (p_phase) // [RULE2]
        else $error("phase step wrong");

    property p_gain467;
        @(posedge clk) disable iff (init)
        cfg_wr && h_comp ##1 !init |->
            comp_gain_modes_four_six_seven == $past(cfg_wdata[2]);
    endproperty
    a_gain467: assert property (p_gain467) // [RULE3]
        else $error("mode 4/6/7 gain not written");

    property p_comp_rst;
        @(posedge clk) sys_rst |=> comp_gain_mode_zero &&
            comp_gain_modes_one_three && !comp_gain_modes_four_six_seven;
    endproperty
    a_comp_rst: assert property (p_comp_rst) // [RULE4] [RULE5]
        else $error("compensation reset value wrong");

    property p_upper_rst;
        @(posedge clk) sys_rst |=> fast_overrange_upper_limit == 8'hFF;
    endproperty
    a_upper_rst: assert property (p_upper_rst) // [RULE6]
        else $error("upper limit reset wrong");

    property p_lower;
        @(posedge clk) disable iff (init)
        cfg_wr && h_low ##1 !init |->
            fast_overrange_lower_limit == $past(cfg_wdata);
    endproperty
    a_lower: assert property (p_lower) // [RULE7]
        else $error("lower limit not written");

    property p_cal;
        @(posedge clk) disable iff (init)
        cfg_wr && h_cal ##1 !init |-> cal_enable == $past(cfg_wdata[3]);
    endproperty
    a_cal: assert property (p_cal) // [RULE8]
        else $error("calibration enable not written");

    property p_rsvd;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && h_comp |=> cfg_rdata[7:3] == 5'h00;
    endproperty
    a_rsvd: assert property (p_rsvd) // [RULE10]
        else $error("reserved bits read nonzero");

    // Calibration register keeps only bit 3; both sides of it read zero
    property p_rsvd_cal;
        @(posedge clk) disable iff (sys_rst)
        cfg_rd && h_cal |=> {cfg_rdata[7:4], cfg_rdata[2:0]} == 7'h00;
    endproperty
    a_rsvd_cal: assert property (p_rsvd_cal) // [RULE10]
        else $error("reserved calibration bits read nonzero");

    c_cal_toggle: cover property (@(posedge clk) disable iff (init)
        $rose(cal_enable) ##[1:1000] $fell(cal_enable));
    c_word_set: cover property (@(posedge clk) disable iff (init)
        cfg_wr && h_hi ##[1:4] cfg_wr && h_lo);
    c_read_comp: cover property (@(posedge clk) disable iff (init)
        cfg_rd && h_comp);
endmodule // rncr_regs
`default_nettype wire

/* File: verif/rncr_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module rncr_regs_tb;
// ----------------------------------------------------------------
// Stimulus, outputs and bookkeeping
// ----------------------------------------------------------------
localparam logic [1:0] CH = 2'b10; // Channel page only
localparam logic [1:0] CV = 2'b01; // Converter page only
localparam logic [1:0] NP = 2'b00; // No page selected
typedef struct {
    logic [1:0] pg;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
} rncr_row_t;
logic clk = 1'b0;
logic sys_rst = 1'b1;
logic soft_rst = 1'b0;
logic channel_page = 1'b0;
logic converter_page = 1'b0;
logic cfg_wr = 1'b0;
logic cfg_rd = 1'b0;
logic [7:0] cfg_addr = 8'h00;
logic [7:0] cfg_wdata = 8'h00;
logic sample_en = 1'b0;
logic [7:0] sample_mag = 8'h00;
logic overrange_speed_select = 1'b1;
logic [7:0] cfg_rdata;
logic [15:0] mixer_frequency_word;
logic [15:0] mixer_phase;
logic g467, g0, g13, overrange_flag, cal_enable;
logic [7:0] up_lim, lo_lim;
logic [7:0] v; // Last value read back
logic [15:0] ph; // Expected phase
int n_mismatch = 0;
int comparisons = 0;
// Reset values, then ordinary write/read rows (reserved bits drop)
rncr_row_t rst_rows [6] = '{'{CV, 8'h07, 8'h00, 8'hFF},
    '{CV, 8'h08, 8'h00, 8'h00}, '{CH, 8'h7A, 8'h00, 8'h00},
    '{CH, 8'h7B, 8'h00, 8'h00}, '{CH, 8'h7E, 8'h00, 8'h03},
    '{CV, 8'hD5, 8'h00, 8'h00}};
rncr_row_t rows [8] = '{'{CH, 8'h7A, 8'h12, 8'h12},
    '{CH, 8'h7B, 8'h34, 8'h34}, '{CH, 8'h7E, 8'hFF, 8'h07},
    '{CH, 8'h7E, 8'h05, 8'h05}, '{CV, 8'h07, 8'hA5, 8'hA5},
    '{CV, 8'h08, 8'h5A, 8'h5A}, '{CV, 8'hD5, 8'hFF, 8'h08},
    '{CV, 8'hD5, 8'h00, 8'h00}};

rncr_regs #(.OVR_DELAY(4)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
    .channel_page(channel_page), .converter_page(converter_page),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .sample_en(sample_en), .sample_mag(sample_mag),
    .overrange_speed_select(overrange_speed_select),
    .mixer_frequency_word(mixer_frequency_word),
    .mixer_phase(mixer_phase), .comp_gain_modes_four_six_seven(g467),
    .comp_gain_mode_zero(g0), .comp_gain_modes_one_three(g13),
    .overrange_flag(overrange_flag), .fast_overrange_upper_limit(up_lim),
    .fast_overrange_lower_limit(lo_lim), .cal_enable(cal_enable)
);

// ----------------------------------------------------------------
// Clock and shared tasks
// ----------------------------------------------------------------
// Free-running 40 MHz clock
always #12.5 clk = ~clk;

// Compare and count; an unknown never passes
task automatic check(input string nm, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
        n_mismatch++;
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
endtask

// One write strobe; returns just after the taking edge
task automatic wr(input logic [1:0] pg, input logic [7:0] a, d);
    @(posedge clk);
    {channel_page, converter_page} <= pg;
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
endtask

// One read strobe; data is sampled an edge later, it stands anyway
task automatic rd(input logic [1:0] pg, input logic [7:0] a);
    @(posedge clk);
    {channel_page, converter_page} <= pg;
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    @(posedge clk);
    #1;
    v = cfg_rdata;
endtask

// One sample; phase is settled on return, flag needs one more edge
task automatic smp(input logic [7:0] m);
    @(posedge clk);
    sample_en <= 1'b1;
    sample_mag <= m;
    @(posedge clk);
    sample_en <= 1'b0;
    #1;
endtask

// Flag lands one edge after the sample is taken
task automatic flag_is(input logic e);
    @(posedge clk);
    #1;
    check("overrange_flag", 16'(overrange_flag), 16'(e));
endtask

// Counts, verdict and end of run
task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
        $display("== PASSED ==");
    end else begin
        $display("== FAILED ==");
    end
    $finish;
endtask

// ----------------------------------------------------------------
// Watchdog: the sequence needs well under 1000 cycles
// ----------------------------------------------------------------
initial begin
    #(25 * 4000);
    n_mismatch++;
    stop_test();
end

// ----------------------------------------------------------------
// Main sequence
// ----------------------------------------------------------------
initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values through the port and at the outputs
    foreach (rst_rows[i]) begin
        rd(rst_rows[i].pg, rst_rows[i].a);
        check("reset readback", 16'(v), 16'(rst_rows[i].e));
    end
    check("word", mixer_frequency_word, 16'h0000);
    check("gains", 16'({g467, g0, g13}), 16'h0003);
    check("limits", {up_lim, lo_lim}, 16'hFF00);
    $display("test reset done");
    // Table rows; calibration set then cleared as a host must
    foreach (rows[i]) begin
        wr(rows[i].pg, rows[i].a, rows[i].d);
        if (rows[i].a == 8'h7A) begin
            // High byte takes effect alone, low byte untouched
            check("word", mixer_frequency_word, 16'h1200);
        end
        if (rows[i].a == 8'hD5) begin
            check("cal_enable", 16'(cal_enable), 16'(rows[i].e[3]));
        end
        rd(rows[i].pg, rows[i].a);
        check("readback", 16'(v), 16'(rows[i].e));
    end
    check("word", mixer_frequency_word, 16'h1234);
    check("gains", 16'({g467, g0, g13}), 16'h0005);
    check("limits", {up_lim, lo_lim}, 16'hA55A);
    $display("test table done");
    // Unmapped place, wrong page, write on no page
    rd(CH, 8'h7C);
    check("unmapped read", 16'(v), 16'h0000);
    rd(CV, 8'h7A);
    check("wrong page read", 16'(v), 16'h0000);
    wr(NP, 8'h07, 8'h11);
    wr(CH, 8'h07, 8'h22);
    check("upper kept", 16'(up_lim), 16'h00A5);
    // Write and read together: read returns the old value
    @(posedge clk);
    {channel_page, converter_page} <= CV;
    cfg_addr <= 8'h08;
    cfg_wdata <= 8'h77;
    cfg_wr <= 1'b1;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    @(posedge clk);
    #1;
    check("old read", 16'(cfg_rdata), 16'h005A);
    check("lower", 16'(lo_lim), 16'h0077);
    $display("test awkward access done");
    // Software reset restores defaults; read data is kept
    @(posedge clk);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    #1;
    check("word", mixer_frequency_word, 16'h0000);
    check("gains", 16'({g467, g0, g13, cal_enable}), 16'h0006);
    check("limits", {up_lim, lo_lim}, 16'hFF00);
    check("rdata kept", 16'(cfg_rdata), 16'h005A);
    $display("test soft reset done");
    // Phase accumulator wraps through zero
    wr(CH, 8'h7A, 8'hC0);
    ph = 16'h0000;
    for (int i = 0; i < 3; i++) begin
        smp(8'h00);
        ph = ph + 16'hC000;
        check("phase", mixer_phase, ph);
    end
    $display("test phase done");
    // Fast flag: above upper sets, between holds, below lower clears
    wr(CV, 8'h07, 8'h64);
    wr(CV, 8'h08, 8'h20);
    smp(8'hC8);
    flag_is(1'b1);
    smp(8'h40);
    flag_is(1'b1);
    smp(8'h10);
    flag_is(1'b0);
    smp(8'h64);
    flag_is(1'b0);
    // Flush the matched line, else the old high level walks out of it
    repeat (4) smp(8'h10);
    // Delay-matched flag lags the fast one by four samples
    @(posedge clk);
    overrange_speed_select <= 1'b0;
    smp(8'hC8);
    flag_is(1'b0);
    repeat (3) smp(8'hC8);
    flag_is(1'b0);
    smp(8'hC8);
    flag_is(1'b1);
    $display("test overrange done");
    stop_test();
end
endmodule // rncr_regs_tb
`default_nettype wire
